// [logic/brw_watchdog.sv]
// Bus request watchdog: supervision state, config guard, idle timers.
// Functional notes
// (R1) Simple mode: config always readable and writable.
// (R2) Advanced: config write refused while running/expired.
// (R3) Bit0 clear: every request triggers except status.
// (R4) Bit0 set: only start command triggers, apart from status read per (R5).
// (R5) Bit1 chooses whether status read triggers.
// (R6) Bit2 set: close all sessions on expiry.
// (R7) Bit7 selects simple or advanced mode.
// (R8) Simple mode: each trigger restarts, also expired.
// (R9) Simple mode stops only by leaving mode.
// (R10) Idle register counts in 10 ms units.
// (R11) Accepted connection starts timer if nonzero.
// (R12) Register changes spare already monitored connections.
// (R13) Silent connection is reset after interval.
// (R14) Timeout in ms; zero means unconfigured.
// (R15) Status codes FFFF, 0000, 0001, 0002.
// (R16) Start 5555, stop 55AA; stop refusals.
// (R17) Expired advanced leaves only by reset command.
// (R18) Millisecond tick drives counters; synchronous clear.
// (R19) Options act when set; unused bits read zero.
`default_nettype none
module brw_watchdog import brw_pkg::*; #(
  parameter int N_CONN = 4,
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SYNC_CLR,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic [7:0] RSP_EXC,
  input wire logic [N_CONN-1:0] CONN_ACCEPT,
  input wire logic [N_CONN-1:0] CONN_TELEGRAM,
  input wire logic [N_CONN-1:0] CONN_CLOSED,
  output logic [N_CONN-1:0] CONN_DROP,
  output logic DROP_ALL_SESSIONS,
  output logic [15:0] STATUS_CODE
);
  brw_state_t st_q, st_d;
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] tmo_q, tmo_d;
  logic [15:0] idle_q, idle_d;
  logic [15:0] cnt_q, cnt_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0] exc_q, exc_d;
  logic drop_all_q, drop_all_d;
  logic [N_CONN-1:0] drop_q, drop_d, conn_drop;
  logic tick, simple, locked, trigger, expire;
  logic is_wr, is_rd, status_acc;

  brw_tick #(
    .CYCLES(TICK_LEN)
  ) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .sync_clr(SYNC_CLR),
    .tick(tick)
  );

  for (genvar i = 0; i < N_CONN; i++) begin : g_conn
    brw_conn u_conn (
      .clk(CLK),
      .rst_n(RST_N),
      .sync_clr(SYNC_CLR),
      .tick(tick),
      .accept(CONN_ACCEPT[i]),
      .idle_units(idle_q),
      .telegram(CONN_TELEGRAM[i]),
      .closed(CONN_CLOSED[i]),
      .drop(conn_drop[i])
    );
  end

  assign is_wr = REQ_VALID && REQ_WRITE;
  assign is_rd = REQ_VALID && !REQ_WRITE;
  assign status_acc = REQ_ADDR == ADDR_STATUS;
  assign simple = cfg_q[CFG_SIMPLE_BIT];                    // [R7]
  assign locked = st_q == BRW_RUNNING || st_q == BRW_EXPIRED;

  // Trigger seen by the supervision counter for the current request.
  always_comb begin
    trigger = 1'b0;
    if (REQ_VALID) begin
      if (status_acc) begin
        trigger = is_rd && cfg_q[CFG_STATUS_TRIG_BIT];      // [R5]
      end else if (cfg_q[CFG_EXPLICIT_BIT]) begin
        trigger = is_wr && REQ_ADDR == ADDR_CMD
          && REQ_WDATA == CMD_START;                        // [R4]
      end else begin
        trigger = 1'b1;                                     // [R3]
      end
    end
  end

  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    tmo_d = tmo_q;
    idle_d = idle_q;
    cnt_d = cnt_q;
    rsp_valid_d = REQ_VALID;
    rdata_d = 16'h0000;
    exc_d = EXC_NONE;
    expire = 1'b0;
    if (is_rd) begin
      unique case (REQ_ADDR)
        ADDR_TIMEOUT: rdata_d = tmo_q;
        ADDR_STATUS: rdata_d = STATUS_CODE;
        ADDR_CONFIG: rdata_d = cfg_q & CFG_MASK;            // [R19]
        ADDR_IDLE: rdata_d = idle_q;
        default: exc_d = EXC_ILLEGAL_FUNC;
      endcase
    end else if (is_wr) begin
      unique case (REQ_ADDR)
        ADDR_CMD: begin
          if (REQ_WDATA == CMD_START) begin
            if (st_q == BRW_NO_TIMEOUT
                || (st_q == BRW_EXPIRED && !simple)) begin
              exc_d = EXC_ILLEGAL_VALUE;                    // [R16]
            end else begin
              st_d = BRW_RUNNING;
              cnt_d = tmo_q;
            end
          end else if (REQ_WDATA == CMD_STOP) begin
            if (simple || st_q == BRW_NO_TIMEOUT
                || st_q == BRW_EXPIRED) begin
              exc_d = EXC_ILLEGAL_VALUE;                    // [R16] [R9]
            end else begin
              st_d = BRW_STOPPED;
            end
          end else if (REQ_WDATA == CMD_RESET) begin
            if (!simple && st_q == BRW_EXPIRED) begin
              st_d = BRW_STOPPED;                           // [R17]
            end else begin
              exc_d = EXC_ILLEGAL_VALUE;                    // [R17]
            end
          end else begin
            exc_d = EXC_ILLEGAL_VALUE;
          end
        end
        ADDR_TIMEOUT, ADDR_CONFIG: begin
          if (!simple && locked) begin
            exc_d = EXC_ILLEGAL_FUNC;                       // [R2]
          end else begin                                    // [R1]
            if (REQ_ADDR == ADDR_CONFIG) begin
              cfg_d = REQ_WDATA & CFG_MASK;                 // [R19]
            end else begin
              tmo_d = REQ_WDATA;
            end
          end
        end
        ADDR_IDLE: idle_d = REQ_WDATA;                      // [R10]
        default: exc_d = EXC_ILLEGAL_FUNC;
      endcase
    end
    // Simple mode re-arms on any trigger, even after expiry.
    if (simple && trigger && tmo_q != 16'h0000) begin
      st_d = BRW_RUNNING;                                   // [R8]
      cnt_d = tmo_q;
    end else if (!simple && trigger && st_q == BRW_RUNNING
                 && st_d == BRW_RUNNING) begin
      cnt_d = tmo_q;
    end else if (st_q == BRW_RUNNING && st_d == BRW_RUNNING
                 && tick) begin                              // [R18]
      if (cnt_q <= 16'h0001) begin
        st_d = BRW_EXPIRED;
        expire = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    // Timeout value decides configured state; simple mode self-starts.
    if (tmo_d == 16'h0000) begin
      st_d = BRW_NO_TIMEOUT;                                // [R14]
      expire = 1'b0;
    end else if (st_d == BRW_NO_TIMEOUT) begin
      st_d = cfg_d[CFG_SIMPLE_BIT] ? BRW_RUNNING : BRW_STOPPED; // [R7]
      cnt_d = tmo_d;
    end else if (cfg_d[CFG_SIMPLE_BIT] && st_d == BRW_STOPPED) begin
      st_d = BRW_RUNNING;
      cnt_d = tmo_d;
    end
    drop_all_d = expire && cfg_q[CFG_DROP_BIT];             // [R6]
    drop_d = conn_drop;
    if (SYNC_CLR) begin
      st_d = BRW_NO_TIMEOUT;
      cfg_d = CFG_RESET;
      tmo_d = TIMEOUT_RESET;
      idle_d = IDLE_RESET;
      cnt_d = 16'h0000;
      drop_all_d = 1'b0;
      drop_d = '0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= BRW_NO_TIMEOUT;
      cfg_q <= CFG_RESET;
      tmo_q <= TIMEOUT_RESET;
      idle_q <= IDLE_RESET;
      cnt_q <= 16'h0000;
      rsp_valid_q <= 1'b0;
      rdata_q <= 16'h0000;
      exc_q <= EXC_NONE;
      drop_all_q <= 1'b0;
      drop_q <= '0;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      tmo_q <= tmo_d;
      idle_q <= idle_d;
      cnt_q <= cnt_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q <= rdata_d;
      exc_q <= exc_d;
      drop_all_q <= drop_all_d;
      drop_q <= drop_d;
    end
  end

  always_comb begin
    unique case (st_q)
      BRW_NO_TIMEOUT: STATUS_CODE = ST_NO_TIMEOUT;          // [R15]
      BRW_STOPPED: STATUS_CODE = ST_STOPPED;
      BRW_RUNNING: STATUS_CODE = ST_RUNNING;
      BRW_EXPIRED: STATUS_CODE = ST_EXPIRED;
    endcase
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP_RDATA = rdata_q;
  assign RSP_EXC = exc_q;
  assign CONN_DROP = drop_q;
  assign DROP_ALL_SESSIONS = drop_all_q;

  a_cfg_write_lock: assert property (@(posedge CLK) disable iff (!RST_N)
    is_wr && REQ_ADDR == ADDR_CONFIG && !simple && locked && !SYNC_CLR
    |=> RSP_EXC == EXC_ILLEGAL_FUNC && $stable(cfg_q)) // [R2]
    else $error("locked config write not refused");
  a_cfg_simple_ok: assert property (@(posedge CLK) disable iff (!RST_N)
    is_wr && REQ_ADDR == ADDR_CONFIG && simple && !SYNC_CLR
    |=> RSP_EXC == EXC_NONE && cfg_q == ($past(REQ_WDATA) & CFG_MASK))
    else $error("simple mode config write lost"); // [R1]
  a_status_notrig: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ_VALID && status_acc && !cfg_q[CFG_STATUS_TRIG_BIT]
    |-> !trigger) // [R3]
    else $error("status access counted as trigger");
  a_explicit_only: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_q[CFG_EXPLICIT_BIT] && trigger
    |-> is_wr && REQ_WDATA == CMD_START) // [R4]
    else $error("explicit mode trigger not a start");
  a_status_trig: assert property (@(posedge CLK) disable iff (!RST_N)
    is_rd && status_acc && cfg_q[CFG_STATUS_TRIG_BIT] |-> trigger) // [R5]
    else $error("status read failed to trigger");
  a_expiry_drop: assert property (@(posedge CLK) disable iff (!RST_N)
    st_q == BRW_RUNNING ##1 st_q == BRW_EXPIRED && !$past(SYNC_CLR)
    |-> DROP_ALL_SESSIONS == $past(cfg_q[CFG_DROP_BIT])) // [R6]
    else $error("session drop on expiry wrong");
  a_simple_rearm: assert property (@(posedge CLK) disable iff (!RST_N)
    simple && trigger && tmo_q != 16'h0000 && !SYNC_CLR
    && !(REQ_WRITE && REQ_ADDR == ADDR_TIMEOUT)
    |=> st_q == BRW_RUNNING && cnt_q == $past(tmo_q)) // [R8]
    else $error("simple trigger did not restart");
  a_no_timeout: assert property (@(posedge CLK) disable iff (!RST_N)
    tmo_q == 16'h0000 |-> STATUS_CODE == ST_NO_TIMEOUT) // [R14] [R15]
    else $error("zero timeout not unconfigured");
  a_expired_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !simple && st_q == BRW_EXPIRED && !SYNC_CLR && tmo_d != 16'h0000
    && !cfg_d[CFG_SIMPLE_BIT]
    && !(is_wr && REQ_ADDR == ADDR_CMD && REQ_WDATA == CMD_RESET)
    |=> st_q == BRW_EXPIRED) // [R17]
    else $error("expired left without reset command");
  // A stop command can never halt the simple mode supervision.
  a_stop_simple_refused: assert property (@(posedge CLK) // [R9]
    disable iff (!RST_N)
    is_wr && REQ_ADDR == ADDR_CMD && REQ_WDATA == CMD_STOP && simple
    && !SYNC_CLR
    |=> RSP_EXC == EXC_ILLEGAL_VALUE && st_q == $past(st_q))
    else $error("stop accepted in simple mode");
  // Bits outside the option mask always read back as zero.
  a_cfg_read_mask: assert property (@(posedge CLK) // [R19]
    disable iff (!RST_N)
    is_rd && REQ_ADDR == ADDR_CONFIG && !SYNC_CLR
    |=> (RSP_RDATA & ~CFG_MASK) == 16'h0000)
    else $error("unused config bits read nonzero");
endmodule
`default_nettype wire

// [logic/brw_pkg.sv]
// Package of constants for the bus request watchdog.
`default_nettype none
package brw_pkg;
  localparam logic [15:0] ADDR_CMD = 16'hFA00;
  localparam logic [15:0] ADDR_TIMEOUT = 16'hFA01;
  localparam logic [15:0] ADDR_STATUS = 16'hFA02;
  localparam logic [15:0] ADDR_CONFIG = 16'hFA03;
  localparam logic [15:0] ADDR_IDLE = 16'hFA04;
  localparam logic [15:0] CMD_START = 16'h5555;
  localparam logic [15:0] CMD_STOP = 16'h55AA;
  localparam logic [15:0] CMD_RESET = 16'hAAAA;
  localparam logic [15:0] ST_NO_TIMEOUT = 16'hFFFF;
  localparam logic [15:0] ST_STOPPED = 16'h0000;
  localparam logic [15:0] ST_RUNNING = 16'h0001;
  localparam logic [15:0] ST_EXPIRED = 16'h0002;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam int CFG_EXPLICIT_BIT = 0;
  localparam int CFG_STATUS_TRIG_BIT = 1;
  localparam int CFG_DROP_BIT = 2;
  localparam int CFG_SIMPLE_BIT = 7;
  localparam logic [15:0] CFG_MASK = 16'h0087;
  localparam logic [15:0] CFG_RESET = 16'h0004;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [15:0] IDLE_RESET = 16'h0000;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int IDLE_UNIT_MS = 10;
  typedef enum logic [1:0] {
    BRW_NO_TIMEOUT,
    BRW_STOPPED,
    BRW_RUNNING,
    BRW_EXPIRED
  } brw_state_t;
endpackage
`default_nettype wire

// [logic/brw_tick.sv]
// Prescaler that makes a one-cycle pulse every millisecond.
`default_nettype none
module brw_tick import brw_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_clr,
  output logic tick
);
  logic [31:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q + 32'h0000_0001;
    if (sync_clr || cnt_q == 32'(CYCLES - 1)) begin
      cnt_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 32'(CYCLES - 1)) && !sync_clr;
endmodule
`default_nettype wire

// [logic/brw_conn.sv]
// Inactivity timer for one TCP connection, counting 10 ms units.
`default_nettype none
module brw_conn import brw_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_clr,
  input wire logic tick,
  input wire logic accept,
  input wire logic [15:0] idle_units,
  input wire logic telegram,
  input wire logic closed,
  output logic drop
);
  logic active_q, active_d;
  logic [15:0] load_q, load_d;
  logic [15:0] units_q, units_d;
  logic [3:0] ms_q, ms_d;

  always_comb begin
    active_d = active_q;
    load_d = load_q;
    units_d = units_q;
    ms_d = ms_q;
    drop = 1'b0;
    if (sync_clr || closed) begin
      active_d = 1'b0;
    end else if (accept) begin
      active_d = idle_units != 16'h0000;            // [R11]
      load_d = idle_units;                           // [R12]
      units_d = idle_units;
      ms_d = 4'h0;
    end else if (active_q && telegram) begin
      units_d = load_q;
      ms_d = 4'h0;
    end else if (active_q && tick) begin            // [R18]
      if (ms_q == 4'(IDLE_UNIT_MS - 1)) begin       // [R10]
        ms_d = 4'h0;
        if (units_q == 16'h0001) begin
          drop = 1'b1;                              // [R13]
          active_d = 1'b0;
        end else begin
          units_d = units_q - 16'h0001;
        end
      end else begin
        ms_d = ms_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      load_q <= 16'h0000;
      units_q <= 16'h0000;
      ms_q <= 4'h0;
    end else begin
      active_q <= active_d;
      load_q <= load_d;
      units_q <= units_d;
      ms_q <= ms_d;
    end
  end

  a_conn_stale_load: assert property (@(posedge clk) disable iff (!rst_n)
    active_q && !accept |=> load_q == $past(load_q)) // [R12]
    else $error("monitored interval changed");
endmodule
`default_nettype wire

// [testbench/brw_master.sv]
// Model of the remote master: register requests and TCP connection events.
`default_nettype none
module brw_master import brw_pkg::*; #(
  parameter int N = 4
) (
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic [7:0] rsp_exc,
  output logic [N-1:0] accept,
  output logic [N-1:0] telegram,
  output logic [N-1:0] closed
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    accept = '0;
    telegram = '0;
    closed = '0;
  end
  // Idle address and data lines show the inverse so stale values never match.
  task automatic access(input logic w, input logic [15:0] a, d,
      output logic [15:0] rd, output logic [7:0] ex, output logic ok);
    int k;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
    ok = 1'b0;
    rd = 16'h0000;
    ex = 8'h00;
    for (k = 0; k < 3 && !ok; k++) begin
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        rd = rsp_rdata;
        ex = rsp_exc;
      end else begin
        @(negedge clk);
      end
    end
  endtask
  // Telegrams sent often enough keep a monitored connection alive.
  task automatic pulse(input logic tel, input logic [N-1:0] m);
    @(negedge clk);
    if (tel) telegram = m;
    else accept = m;
    @(negedge clk);
    accept = '0;
    telegram = '0;
  endtask
endmodule
`default_nettype wire

// [testbench/bus_request_watchdog_bench.sv]
// Self-checking bench for the bus request watchdog.
`default_nettype none
module bus_request_watchdog_bench import brw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic w;
    logic [15:0] a, d, rd;
    logic [7:0] ex;
    logic [15:0] st;
  } brw_row_t;
  localparam logic [15:0] Z = 16'h0000;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SYNC_CLR = 1'b0;
  logic req_valid, req_write, rsp_valid, drop_all;
  logic [15:0] req_addr, req_wdata, rsp_rdata, status;
  logic [7:0] rsp_exc;
  logic [3:0] acc, tel, clo, cdrop;
  logic [15:0] drop_n [4] = '{default: 16'h0000};
  int n_fail = 0;
  int checks_done = 0;
  brw_row_t rows [18] = '{
    '{1'b0, ADDR_CONFIG, Z, 16'h0004, EXC_NONE, ST_NO_TIMEOUT},
    '{1'b0, ADDR_STATUS, Z, ST_NO_TIMEOUT, EXC_NONE, ST_NO_TIMEOUT},
    '{1'b1, ADDR_CMD, CMD_START, Z, EXC_ILLEGAL_VALUE, ST_NO_TIMEOUT},
    '{1'b1, ADDR_CMD, CMD_STOP, Z, EXC_ILLEGAL_VALUE, ST_NO_TIMEOUT},
    '{1'b1, ADDR_TIMEOUT, 16'h0003, Z, EXC_NONE, ST_STOPPED},
    '{1'b0, ADDR_TIMEOUT, Z, 16'h0003, EXC_NONE, ST_STOPPED},
    '{1'b1, ADDR_CMD, CMD_STOP, Z, EXC_NONE, ST_STOPPED},
    '{1'b1, ADDR_CMD, CMD_RESET, Z, EXC_ILLEGAL_VALUE, ST_STOPPED},
    '{1'b1, ADDR_CMD, 16'h1234, Z, EXC_ILLEGAL_VALUE, ST_STOPPED},
    '{1'b0, ADDR_CMD, Z, Z, EXC_ILLEGAL_FUNC, ST_STOPPED},
    '{1'b0, 16'hFA05, Z, Z, EXC_ILLEGAL_FUNC, ST_STOPPED},
    '{1'b1, ADDR_CONFIG, 16'hFF7F, Z, EXC_NONE, ST_STOPPED},
    '{1'b0, ADDR_CONFIG, Z, 16'h0007, EXC_NONE, ST_STOPPED},
    '{1'b1, ADDR_CONFIG, 16'h0004, Z, EXC_NONE, ST_STOPPED},
    '{1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE, ST_RUNNING},
    '{1'b1, ADDR_CONFIG, Z, Z, EXC_ILLEGAL_FUNC, ST_RUNNING},
    '{1'b0, ADDR_CONFIG, Z, 16'h0004, EXC_NONE, ST_RUNNING},
    '{1'b1, ADDR_CMD, CMD_STOP, Z, EXC_NONE, ST_STOPPED}};

  always #12.5 CLK = ~CLK;
  // Drops are counted on the falling edge, where the registered pulse is settled.
  always @(negedge CLK) begin
    for (int i = 0; i < 4; i++) begin
      if (cdrop[i] === 1'b1) drop_n[i]++;
    end
  end

  brw_watchdog #(.N_CONN(4), .TICK_LEN(4)) i_brw_watchdog (
    .CLK(CLK), .RST_N(RST_N), .SYNC_CLR(SYNC_CLR), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_EXC(rsp_exc),
    .CONN_ACCEPT(acc), .CONN_TELEGRAM(tel), .CONN_CLOSED(clo),
    .CONN_DROP(cdrop), .DROP_ALL_SESSIONS(drop_all), .STATUS_CODE(status));
  brw_master #(.N(4)) i_brw_master (
    .clk(CLK), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc), .accept(acc), .telegram(tel),
    .closed(clo));

  task automatic chk(input string what, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic op(input logic w, input logic [15:0] a, d, erd,
      input logic [7:0] eex);
    logic [15:0] rd;
    logic [7:0] ex;
    logic ok;
    i_brw_master.access(w, a, d, rd, ex, ok);
    chk("rsp_valid", 16'h0001, {15'h0000, ok});
    chk("rsp_exc", {8'h00, eex}, {8'h00, ex});
    chk("rsp_rdata", erd, rd);
  endtask
  // Six requests spaced closer than the timeout, then the state is looked at.
  task automatic keep(input logic w, input logic [15:0] a, d, st);
    logic [15:0] rd;
    logic [7:0] ex;
    logic ok;
    repeat (6) begin
      repeat (4) @(negedge CLK);
      i_brw_master.access(w, a, d, rd, ex, ok);
    end
    repeat (4) @(negedge CLK);
    chk("status", st, STATUS_CODE_w());
  endtask
  function automatic logic [15:0] STATUS_CODE_w();
    return status;
  endfunction
  task automatic wait_exp(input logic [15:0] ndrop);
    logic [15:0] n;
    n = 16'h0000;
    repeat (30) begin
      @(negedge CLK);
      if (drop_all === 1'b1) n++;
    end
    chk("drop_all", ndrop, n);
    chk("status", ST_EXPIRED, status);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (4000) @(negedge CLK);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge CLK);
    chk("status_rst", ST_NO_TIMEOUT, status);
    chk("rsp_valid_rst", Z, {15'h0000, rsp_valid});
    RST_N = 1'b1;
    foreach (rows[i]) begin
      op(rows[i].w, rows[i].a, rows[i].d, rows[i].rd, rows[i].ex);
      chk("status", rows[i].st, status);
    end
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE);
    wait_exp(16'h0001);
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_ILLEGAL_VALUE);
    op(1'b1, ADDR_CMD, CMD_STOP, Z, EXC_ILLEGAL_VALUE);
    op(1'b1, ADDR_CONFIG, Z, Z, EXC_ILLEGAL_FUNC);
    op(1'b1, ADDR_CMD, CMD_RESET, Z, EXC_NONE);
    chk("status", ST_STOPPED, status);
    op(1'b1, ADDR_CONFIG, Z, Z, EXC_NONE);
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE);
    wait_exp(Z);
    op(1'b1, ADDR_CMD, CMD_RESET, Z, EXC_NONE);
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE);
    keep(1'b0, ADDR_IDLE, Z, ST_RUNNING);
    keep(1'b0, ADDR_STATUS, Z, ST_EXPIRED);
    op(1'b1, ADDR_CMD, CMD_RESET, Z, EXC_NONE);
    op(1'b1, ADDR_CONFIG, 16'h0002, Z, EXC_NONE);
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE);
    keep(1'b0, ADDR_STATUS, Z, ST_RUNNING);
    op(1'b1, ADDR_CMD, CMD_STOP, Z, EXC_NONE);
    op(1'b1, ADDR_CONFIG, 16'h0001, Z, EXC_NONE);
    op(1'b1, ADDR_CMD, CMD_START, Z, EXC_NONE);
    keep(1'b1, ADDR_CMD, CMD_START, ST_RUNNING);
    keep(1'b0, ADDR_IDLE, Z, ST_EXPIRED);
    op(1'b1, ADDR_CMD, CMD_RESET, Z, EXC_NONE);
    op(1'b1, ADDR_CONFIG, 16'h0084, Z, EXC_NONE);
    chk("status", ST_RUNNING, status);
    op(1'b1, ADDR_CMD, CMD_STOP, Z, EXC_ILLEGAL_VALUE);
    op(1'b1, ADDR_CONFIG, 16'h0084, Z, EXC_NONE);
    op(1'b0, ADDR_CONFIG, Z, 16'h0084, EXC_NONE);
    wait_exp(16'h0001);
    op(1'b1, ADDR_CONFIG, 16'h0084, Z, EXC_NONE);
    chk("status", ST_RUNNING, status);
    op(1'b1, ADDR_CONFIG, 16'h0004, Z, EXC_NONE);
    op(1'b1, ADDR_CMD, CMD_STOP, Z, EXC_NONE);
    chk("status", ST_STOPPED, status);
    op(1'b1, ADDR_IDLE, Z, Z, EXC_NONE);
    i_brw_master.pulse(1'b0, 4'b1000);
    op(1'b1, ADDR_IDLE, 16'h0002, Z, EXC_NONE);
    i_brw_master.pulse(1'b0, 4'b0001);
    op(1'b1, ADDR_IDLE, 16'h0001, Z, EXC_NONE);
    i_brw_master.pulse(1'b0, 4'b0110);
    repeat (3) begin
      repeat (18) @(negedge CLK);
      i_brw_master.pulse(1'b1, 4'b0100);
    end
    chk("drop1", 16'h0001, drop_n[1]);
    chk("drop0", Z, drop_n[0]);
    repeat (30) @(negedge CLK);
    chk("drop0", 16'h0001, drop_n[0]);
    chk("drop2", Z, drop_n[2]);
    chk("drop3", Z, drop_n[3]);
    SYNC_CLR = 1'b1;
    @(negedge CLK);
    SYNC_CLR = 1'b0;
    chk("status", ST_NO_TIMEOUT, status);
    op(1'b0, ADDR_CONFIG, Z, 16'h0004, EXC_NONE);
    print_verdict();
  end
endmodule
`default_nettype wire
